// ---- shared/eipc_pkg.sv ----
// Constants, record and state types of the configuration image loader.
// Assumes a single 20 MHz core clock; nothing here holds state.
package eipc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_PERIOD_NS = 50;
    // Standard mode, 100 kHz: four quarter phases per bit
    localparam int I2C_BIT_TIME_NS = 10000;
    // Least time, rounded up
    localparam int QUARTER_CYCLES = (I2C_BIT_TIME_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int QUARTER_W = $clog2(QUARTER_CYCLES);
    localparam int BOOT_SETTLE_CYCLES = 2;

    ////////////////////////////////////////////////////////////////////////////
    // Image format
    localparam logic [7:0] FORMAT_MARKER = 8'hAA;
    localparam logic [3:0] EEPROM_ADDR_HI = 4'hA;
    localparam logic [7:0] MEM_START_HI = 8'h00;
    localparam logic [7:0] MEM_START_LO = 8'h00;
    localparam logic [15:0] CRC_POLY = 16'h8005;
    localparam logic [15:0] CRC_INIT = 16'h0000;
    localparam logic [23:0] WORD_STRIDE = 24'h000004;
    localparam int FIFO_DEPTH = 2;

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef struct packed {
        logic [23:0] addr;
        logic [31:0] data;
        logic narrow;
    } eipc_wr_t;

    typedef enum logic [5:0] {
        L_IDLE  = 6'h01,
        L_START = 6'h02,
        L_TX    = 6'h04,
        L_RX    = 6'h08,
        L_HOLD  = 6'h10,
        L_STOP  = 6'h20
    } eipc_link_t;

    typedef enum logic [4:0] {
        P_MARK  = 5'h01,
        P_COUNT = 5'h02,
        P_HDR   = 5'h04,
        P_DATA  = 5'h08,
        P_CRC   = 5'h10
    } eipc_parse_t;

endpackage

// ---- design/eipc_fifo.sv ----
// Shift-style buffer for register writes; the head entry is a flop.
// Assumes push and pop come from the core clock domain.
`timescale 1ns/1ps
`default_nettype none
module eipc_fifo #(
    parameter int W = 57,
    parameter int DEPTH = 2
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    localparam int CW = $clog2(DEPTH + 1);

    logic [W-1:0] mem [DEPTH];
    logic [CW-1:0] cnt;
    wire push = in_valid_i && in_ready_o;
    wire pop = out_valid_o && out_ready_i;
    wire [CW-1:0] base = cnt - CW'(pop);
    wire [CW-1:0] next_cnt = base + CW'(push);

    // Full refuses a push even when a pop is due: simple, one cycle lost
    assign in_ready_o = (cnt != CW'(DEPTH));
    assign out_data_o = mem[0];

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt <= '0;
            out_valid_o <= 1'b0;
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;
            end
        end else begin
            cnt <= next_cnt;
            out_valid_o <= (next_cnt != '0);
            for (int i = 0; i < DEPTH; i++) begin
                if (push && base == CW'(i)) begin
                    mem[i] <= in_data_i;
                end else if (pop && i < DEPTH - 1) begin
                    mem[i] <= mem[(i + 1) % DEPTH];
                end
            end
        end
    end
endmodule
`default_nettype wire

// ---- design/eipc_loader.sv ----
// Boot loader: reads a configuration image from a serial EEPROM as a
// temporary bus master, parses it and issues register writes.
// Assumes open-drain pins resolved outside; register sink on core clock.
`timescale 1ns/1ps
`default_nettype none
module eipc_loader (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic boot_master_select_i,
    input wire logic start_i,
    input wire logic [2:0] address_strap_pins_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic scl_oe_o,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic narrow_reg_i,
    output logic [23:0] target_addr_o,
    output logic wr_valid_o,
    input wire logic wr_ready_i,
    output eipc_pkg::eipc_wr_t wr_o,
    output logic master_active_o,
    output logic done_o,
    output logic format_error_o,
    output logic link_error_o,
    output logic image_crc_mismatch_flag_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Functions
    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            r = {r[14:0], b[i]} ^ (r[15] ? eipc_pkg::CRC_POLY : 16'h0000);
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [5:0] sync1;
    logic [5:0] sync2;
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            sync1 <= 6'h00;
            sync2 <= 6'h00;
        end else begin
            sync1 <= {boot_master_select_i, address_strap_pins_i, scl_i, sda_i};
            sync2 <= sync1;
        end
    end
    wire boot_sel_s = sync2[5];
    wire [2:0] strap_s = sync2[4:2];
    wire scl_s = sync2[1];
    wire sda_s = sync2[0];

    ////////////////////////////////////////////////////////////////////////////
    // State
    eipc_pkg::eipc_link_t lst;
    eipc_pkg::eipc_parse_t pst;
    logic [eipc_pkg::QUARTER_W-1:0] qcnt;
    logic [1:0] phase;
    logic [3:0] bitn;
    logic [1:0] tx_idx;
    logic [7:0] tx_sh;
    logic [7:0] rx_sh;
    logic ack_bad;
    logic nack;
    logic [6:0] dev_addr;
    logic [1:0] boot_cnt;
    logic [1:0] bidx;
    logic [15:0] blk_left;
    logic [9:0] words_left;
    logic [23:0] acc;
    logic [15:0] crc;
    logic [7:0] crc_hi;

    ////////////////////////////////////////////////////////////////////////////
    // Decode
    wire boot_go = (boot_cnt == 2'(eipc_pkg::BOOT_SETTLE_CYCLES)) && boot_sel_s;
    wire go = (lst == eipc_pkg::L_IDLE) && (start_i || boot_go);
    wire running = (lst == eipc_pkg::L_START) || (lst == eipc_pkg::L_TX) ||
                   (lst == eipc_pkg::L_RX) || (lst == eipc_pkg::L_STOP);
    // Slave may stretch the clock while it is released
    wire stretch = running && (phase == 2'h1) && !scl_s;
    wire tick = running && !stretch && (qcnt == eipc_pkg::QUARTER_W'(eipc_pkg::QUARTER_CYCLES - 1));
    wire op_end = tick && (phase == 2'h3);
    wire [7:0] b = rx_sh;
    wire word_last = narrow_reg_i || (bidx == 2'h3);
    wire push_word = (lst == eipc_pkg::L_HOLD) && (pst == eipc_pkg::P_DATA) && word_last;
    wire fifo_ready;
    wire take = (lst == eipc_pkg::L_HOLD) && !(push_word && !fifo_ready);
    wire mark_bad = (pst == eipc_pkg::P_MARK) && (b != eipc_pkg::FORMAT_MARKER);
    wire crc_end = (pst == eipc_pkg::P_CRC) && (bidx == 2'h1);
    wire [15:0] crc_rx = {crc_hi, b};
    wire [31:0] word = narrow_reg_i ? {24'h000000, b} : {acc, b};
    eipc_pkg::eipc_wr_t wr_in;
    assign wr_in = '{addr: target_addr_o, data: word, narrow: narrow_reg_i};

    // Bus bytes of the write-address-then-read burst
    wire [7:0] tx_byte0 = {dev_addr, 1'b0};
    wire [7:0] tx_byte3 = {dev_addr, 1'b1};
    wire [7:0] tx_next = (tx_idx == 2'h0) ? eipc_pkg::MEM_START_HI : eipc_pkg::MEM_START_LO;

    // Pin drive, open drain: enable high pulls the line low
    wire next_scl_oe = (running && lst != eipc_pkg::L_STOP && (phase == 2'h0 || phase == 2'h3)) ||
                       (lst == eipc_pkg::L_STOP && phase == 2'h0) || (lst == eipc_pkg::L_HOLD);
    wire next_sda_oe = ((lst == eipc_pkg::L_START) && phase[1]) ||
                       ((lst == eipc_pkg::L_TX) && bitn != 4'h8 && !tx_sh[7]) ||
                       ((lst == eipc_pkg::L_RX) && bitn == 4'h8 && !nack) ||
                       ((lst == eipc_pkg::L_STOP) && !phase[1]);

    ////////////////////////////////////////////////////////////////////////////
    // Pins and timing
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            scl_o <= 1'b0;
            sda_o <= 1'b0;
            scl_oe_o <= 1'b0;
            sda_oe_o <= 1'b0;
            qcnt <= '0;
            phase <= 2'h0;
            boot_cnt <= 2'h0;
        end else begin
            scl_oe_o <= next_scl_oe;
            sda_oe_o <= next_sda_oe;
            if (boot_cnt != 2'h3) begin
                boot_cnt <= boot_cnt + 2'h1;
            end
            if (!running || tick) begin
                qcnt <= '0;
            end else if (!stretch) begin
                qcnt <= qcnt + eipc_pkg::QUARTER_W'(1);
            end
            if (!running) begin
                phase <= 2'h0;
            end else if (tick) begin
                phase <= phase + 2'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link sequencer
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            lst <= eipc_pkg::L_IDLE;
            bitn <= 4'h0;
            tx_idx <= 2'h0;
            tx_sh <= 8'h00;
            rx_sh <= 8'h00;
            ack_bad <= 1'b0;
            nack <= 1'b0;
            dev_addr <= 7'h00;
            master_active_o <= 1'b0;
            done_o <= 1'b0;
            link_error_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (tick && phase == 2'h2) begin
                if (lst == eipc_pkg::L_RX && bitn != 4'h8) begin
                    rx_sh <= {rx_sh[6:0], sda_s};
                end
                if (lst == eipc_pkg::L_TX && bitn == 4'h8) begin
                    ack_bad <= sda_s;
                end
            end
            unique case (lst)
                eipc_pkg::L_IDLE: begin
                    if (go) begin
                        dev_addr <= {eipc_pkg::EEPROM_ADDR_HI, strap_s};
                        tx_idx <= 2'h0;
                        nack <= 1'b0;
                        link_error_o <= 1'b0;
                        master_active_o <= 1'b1;
                        lst <= eipc_pkg::L_START;
                    end
                end
                eipc_pkg::L_START: begin
                    if (op_end) begin
                        tx_sh <= (tx_idx == 2'h3) ? tx_byte3 : tx_byte0;
                        bitn <= 4'h0;
                        lst <= eipc_pkg::L_TX;
                    end
                end
                eipc_pkg::L_TX: begin
                    if (op_end && bitn != 4'h8) begin
                        tx_sh <= {tx_sh[6:0], 1'b0};
                        bitn <= bitn + 4'h1;
                    end else if (op_end) begin
                        bitn <= 4'h0;
                        if (ack_bad) begin
                            link_error_o <= 1'b1;
                            lst <= eipc_pkg::L_STOP;
                        end else if (tx_idx == 2'h2) begin
                            tx_idx <= 2'h3;
                            lst <= eipc_pkg::L_START;
                        end else if (tx_idx == 2'h3) begin
                            lst <= eipc_pkg::L_RX;
                        end else begin
                            tx_sh <= tx_next;
                            tx_idx <= tx_idx + 2'h1;
                        end
                    end
                end
                eipc_pkg::L_RX: begin
                    if (op_end && bitn == 4'h7) begin
                        lst <= eipc_pkg::L_HOLD;
                    end else if (op_end && bitn == 4'h8) begin
                        bitn <= 4'h0;
                        lst <= nack ? eipc_pkg::L_STOP : eipc_pkg::L_RX;
                    end else if (op_end) begin
                        bitn <= bitn + 4'h1;
                    end
                end
                eipc_pkg::L_HOLD: begin
                    // Clock held low while the buffer is full
                    if (take) begin
                        nack <= mark_bad || crc_end;
                        bitn <= 4'h8;
                        lst <= eipc_pkg::L_RX;
                    end
                end
                eipc_pkg::L_STOP: begin
                    if (op_end) begin
                        master_active_o <= 1'b0;
                        done_o <= 1'b1;
                        lst <= eipc_pkg::L_IDLE;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Image parser, one byte per take
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pst <= eipc_pkg::P_MARK;
            bidx <= 2'h0;
            blk_left <= 16'h0000;
            words_left <= 10'h000;
            acc <= 24'h000000;
            crc <= eipc_pkg::CRC_INIT;
            crc_hi <= 8'h00;
            target_addr_o <= 24'h000000;
            format_error_o <= 1'b0;
            image_crc_mismatch_flag_o <= 1'b0;
        end else if (go) begin
            pst <= eipc_pkg::P_MARK;
            bidx <= 2'h0;
            crc <= eipc_pkg::CRC_INIT;
            format_error_o <= 1'b0;
            image_crc_mismatch_flag_o <= 1'b0;
        end else if (take) begin
            if (pst != eipc_pkg::P_CRC) begin
                crc <= crc_step(crc, b);
            end
            bidx <= bidx + 2'h1;
            unique case (pst)
                eipc_pkg::P_MARK: begin
                    if (mark_bad) begin
                        format_error_o <= 1'b1;
                    end else if (bidx == 2'h1) begin
                        bidx <= 2'h0;
                        pst <= eipc_pkg::P_COUNT;
                    end
                end
                eipc_pkg::P_COUNT: begin
                    if (bidx == 2'h0) begin
                        blk_left[15:8] <= b;
                    end else begin
                        blk_left[7:0] <= b;
                        bidx <= 2'h0;
                        pst <= eipc_pkg::P_HDR;
                    end
                end
                eipc_pkg::P_HDR: begin
                    unique case (bidx)
                        2'h0: words_left[7:0] <= b;
                        2'h1: begin
                            words_left[9:8] <= b[7:6];
                            target_addr_o[23:18] <= b[5:0];
                        end
                        2'h2: target_addr_o[17:10] <= b;
                        2'h3: begin
                            // Low two bits always zero
                            target_addr_o[9:0] <= {b, 2'h0};
                            pst <= eipc_pkg::P_DATA;
                        end
                    endcase
                end
                eipc_pkg::P_DATA: begin
                    acc <= {acc[15:0], b};
                    if (word_last) begin
                        bidx <= 2'h0;
                        target_addr_o <= target_addr_o + eipc_pkg::WORD_STRIDE;
                        if (words_left != 10'h000) begin
                            words_left <= words_left - 10'h001;
                        end else if (blk_left != 16'h0000) begin
                            blk_left <= blk_left - 16'h0001;
                            pst <= eipc_pkg::P_HDR;
                        end else begin
                            pst <= eipc_pkg::P_CRC;
                        end
                    end
                end
                eipc_pkg::P_CRC: begin
                    crc_hi <= b;
                    if (crc_end && crc_rx != crc) begin
                        // Writes already issued stay in place
                        image_crc_mismatch_flag_o <= 1'b1;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write buffer
    eipc_fifo #(
        .W($bits(eipc_pkg::eipc_wr_t)),
        .DEPTH(eipc_pkg::FIFO_DEPTH)
    ) u_fifo (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .in_valid_i(push_word && fifo_ready),
        .in_ready_o(fifo_ready),
        .in_data_i(wr_in),
        .out_valid_o(wr_valid_o),
        .out_ready_i(wr_ready_i),
        .out_data_o(wr_o)
    );
endmodule
`default_nettype wire

// ---- tb/eipc_loader_properties.sv ----
// Checker of the loader's outputs, bound to every eipc_loader.
// Assumes one core clock and the asynchronous reset rst_i.
`timescale 1ns/1ps
`default_nettype none
module eipc_loader_properties (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic scl_oe_o,
    input wire logic sda_oe_o,
    input wire logic [23:0] target_addr_o,
    input wire logic wr_valid_o,
    input wire logic wr_ready_i,
    input wire eipc_pkg::eipc_wr_t wr_o,
    input wire logic master_active_o,
    input wire logic done_o,
    input wire logic format_error_o,
    input wire logic link_error_o,
    input wire logic image_crc_mismatch_flag_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////////////////////////
    sequence s_begin;
        !master_active_o && start_i;
    endsequence
    sequence s_run_end;
        master_active_o ##1 !master_active_o;
    endsequence
    chk_start_taken: assert property (s_begin |=> master_active_o)
        else $error("start not taken while idle");
    chk_flags_clear: assert property ($rose(master_active_o) |->
        !format_error_o && !link_error_o && !image_crc_mismatch_flag_o)
        else $error("flags not cleared at start");
    chk_flag_sticky: assert property ($fell(image_crc_mismatch_flag_o) |-> $rose(master_active_o))
        else $error("mismatch flag dropped outside a start");
    chk_done_pulse: assert property (s_run_end |-> done_o ##1 !done_o)
        else $error("done missing or too long at run end");
    chk_done_only_end: assert property (done_o |-> !master_active_o && $past(master_active_o))
        else $error("done without run end");
    chk_bus_release: assert property (!master_active_o |-> !scl_oe_o && !sda_oe_o)
        else $error("bus held while not master");
    chk_wr_hold: assert property (wr_valid_o && !wr_ready_i |=> wr_valid_o && $stable(wr_o))
        else $error("write changed before taken");
    chk_wr_align: assert property (wr_valid_o |-> wr_o.addr[1:0] == 2'h0 && target_addr_o[1:0] == 2'h0)
        else $error("register address not word aligned");
    chk_narrow_byte: assert property (wr_valid_o && wr_o.narrow |-> wr_o.data[31:8] == 24'h000000)
        else $error("narrow write carries upper bits");
    chk_format_stop: assert property ($rose(format_error_o) |-> !wr_valid_o ##[0:1000] done_o)
        else $error("bad marker did not end the run");
    chk_nack_stop: assert property ($rose(link_error_o) |-> ##[0:1000] done_o)
        else $error("refused byte did not end the run");
endmodule
bind eipc_loader eipc_loader_properties u_props (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .start_i(start_i), .scl_oe_o(scl_oe_o), .sda_oe_o(sda_oe_o),
    .target_addr_o(target_addr_o), .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i), .wr_o(wr_o),
    .master_active_o(master_active_o), .done_o(done_o), .format_error_o(format_error_o),
    .link_error_o(link_error_o), .image_crc_mismatch_flag_o(image_crc_mismatch_flag_o));
`default_nettype wire

// ---- tb/eipc_eeprom_model.sv ----
// Behavioural serial EEPROM that answers one burst read.
// Assumes open-drain lines resolved by the bench; image written into mem.
`timescale 1ns/1ps
`default_nettype none
module eipc_eeprom_model (
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic [2:0] strap_i,
    input wire logic stretch_i,
    output logic scl_low_o,
    output logic sda_low_o
);
    logic [7:0] mem [0:63];
    logic [7:0] sh = 8'h00;
    logic [15:0] ptr = 16'h0000;
    logic act = 1'b0;
    logic first = 1'b0;
    logic out = 1'b0;
    logic pend = 1'b0;
    logic mack = 1'b0;
    logic drv;
    int bc = 0;
    int nb = 0;
    initial begin
        scl_low_o = 1'b0;
        sda_low_o = 1'b0;
    end
    ////////////////////////////////////////////////////////////
    always @(negedge sda_i) begin
        if (scl_i) begin
            act = 1'b1;
            first = 1'b1;
            out = 1'b0;
            bc = 0;
            nb = 0;
        end
    end
    always @(posedge sda_i) begin
        if (scl_i) act = 1'b0;
    end
    always @(posedge scl_i) begin
        if (act && bc < 8) sh = {sh[6:0], sda_i};
        if (act && bc == 8) mack = !sda_i;
    end
    // Data changes only here, while the clock line is low
    always @(negedge scl_i) begin
        drv = 1'b0;
        if (act && first) begin
            first = 1'b0;
        end else if (act) begin
            bc = bc + 1;
            if (bc == 8 && !out) begin
                if (nb == 0) begin
                    pend = sh[0];
                    act = sh[7:1] == {4'hA, strap_i};
                end else if (nb == 1) begin
                    ptr[15:8] = sh;
                end else begin
                    ptr[7:0] = sh;
                end
                drv = act;
            end
            if (bc == 9) begin
                bc = 0;
                nb = nb + 1;
                if (out && mack) ptr = ptr + 16'h0001;
                out = (out && mack) || pend;
                pend = 1'b0;
                // Held past the next low phase so the master must wait in its high phase
                if (stretch_i) begin
                    scl_low_o = 1'b1;
                    scl_low_o <= #6000 1'b0;
                end
            end
            if (out && bc < 8) drv = !mem[ptr[5:0]][7 - bc];
        end
        sda_low_o = drv;
    end
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench: loader, behavioural EEPROM and a register sink.
// Assumes the 20 MHz core clock; stimulus changes on rising edges.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic bms = 1'b1;
    logic start = 1'b0;
    logic stretch = 1'b0;
    logic ready = 1'b0;
    logic [2:0] strap = 3'h5;
    logic [2:0] m_strap = 3'h5;
    logic scl_oe, sda_oe, scl_low, sda_low, valid, active, done, ferr, lerr, cerr, scl_d, sda_d;
    logic [23:0] taddr;
    eipc_pkg::eipc_wr_t wr;
    eipc_pkg::eipc_wr_t got [$];
    int error_cnt = 0;
    int num_checks = 0;
    int dones = 0;
    wire logic scl_w = !(scl_oe || scl_low);
    wire logic sda_w = !(sda_oe || sda_low);
    // Byte-wide registers live in one page
    wire logic narrow = taddr[23:16] == 8'hE0;
    always #25 core_clk_i = ~core_clk_i;
    eipc_loader DUT (.core_clk_i(core_clk_i), .rst_i(rst_i), .boot_master_select_i(bms), .start_i(start),
        .address_strap_pins_i(strap), .scl_i(scl_w), .sda_i(sda_w), .scl_o(scl_d), .scl_oe_o(scl_oe), .sda_o(sda_d),
        .sda_oe_o(sda_oe), .narrow_reg_i(narrow), .target_addr_o(taddr), .wr_valid_o(valid),
        .wr_ready_i(ready), .wr_o(wr), .master_active_o(active), .done_o(done), .format_error_o(ferr),
        .link_error_o(lerr), .image_crc_mismatch_flag_o(cerr));
    eipc_eeprom_model eep (.scl_i(scl_w), .sda_i(sda_w), .strap_i(m_strap), .stretch_i(stretch),
        .scl_low_o(scl_low), .sda_low_o(sda_low));
    always @(posedge core_clk_i) begin
        if (valid === 1'b1 && ready === 1'b1) got.push_back(wr);
        if (done === 1'b1) dones++;
    end
    ////////////////////////////////////////////////////////////
    task automatic check(string what, logic [63:0] exp, logic [63:0] seen);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    function automatic logic [15:0] crc16(logic [7:0] b [$]);
        logic [15:0] c;
        logic fb;
        c = 16'h0000;
        foreach (b[i]) begin
            for (int k = 7; k >= 0; k--) begin
                fb = c[15];
                c = {c[14:0], b[i][k]} ^ (fb ? 16'h8005 : 16'h0000);
            end
        end
        return c;
    endfunction
    task automatic load(logic [7:0] body [$], logic [15:0] flip);
        logic [15:0] c;
        c = crc16(body) ^ flip;
        for (int i = 0; i < 64; i++) eep.mem[i] = 8'hFF;
        foreach (body[i]) eep.mem[i] = body[i];
        eep.mem[body.size()] = c[15:8];
        eep.mem[body.size() + 1] = c[7:0];
    endtask
    task automatic run(logic by_cmd);
        int n;
        got.delete();
        dones = 0;
        if (by_cmd) begin
            @(posedge core_clk_i) start <= 1'b1;
            @(posedge core_clk_i) start <= 1'b0;
        end
        n = 0;
        while (dones == 0 && n < 60000) begin
            @(posedge core_clk_i);
            n++;
        end
        repeat (4) @(posedge core_clk_i);
    endtask
    task automatic outcome(logic [3:0] flags, int nwr);
        check("flags", 64'(flags), 64'({ferr, lerr, cerr, active}));
        check("writes", 64'(nwr), 64'(got.size()));
        check("done pulses", 64'h1, 64'(dones));
        check("line data", 64'h0, 64'({scl_d, sda_d}));
    endtask
    task automatic expect_wr(int i, logic [23:0] a, logic [31:0] d, logic nw);
        check("write", 64'({a, d, nw}), 64'(got[i]));
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_boot();
        load('{8'hAA, 8'hAA, 8'h00, 8'h01, 8'h01, 8'h2A, 8'h00, 8'h01, 8'h12, 8'h34, 8'h56, 8'h78,
            8'h9A, 8'hBC, 8'hDE, 8'hF0, 8'h01, 8'h38, 8'h00, 8'h00, 8'h5A, 8'hC3}, 16'h0000);
        // Sink stalls long enough to fill the buffer and stretch the link
        fork
            begin
                wait (valid === 1'b1);
                repeat (18000) @(posedge core_clk_i);
                ready <= 1'b1;
            end
        join_none
        run(1'b0);
        outcome(4'h0, 4);
        expect_wr(0, 24'hA80004, 32'h12345678, 1'b0);
        expect_wr(1, 24'hA80008, 32'h9ABCDEF0, 1'b0);
        expect_wr(2, 24'hE00000, 32'h0000005A, 1'b1);
        expect_wr(3, 24'hE00004, 32'h000000C3, 1'b1);
        $display("test boot load done");
    endtask
    task automatic t_bad_marker();
        stretch <= 1'b1;
        load('{8'hAA, 8'h55, 8'h00, 8'h00}, 16'h0000);
        run(1'b1);
        outcome(4'h8, 0);
        $display("test bad marker done");
    endtask
    task automatic t_crc_flag();
        load('{8'hAA, 8'hAA, 8'h00, 8'h00, 8'h00, 8'h38, 8'h00, 8'h01, 8'h7E}, 16'h0100);
        run(1'b1);
        outcome(4'h2, 1);
        expect_wr(0, 24'hE00004, 32'h0000007E, 1'b1);
        $display("test crc mismatch done");
    endtask
    task automatic t_nack();
        m_strap <= 3'h2;
        run(1'b1);
        outcome(4'h4, 0);
        $display("test refused address done");
    endtask
    task automatic conclude();
        $display("checks %0d, mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge core_clk_i);
        rst_i <= 1'b0;
        t_boot();
        t_bad_marker();
        t_crc_flag();
        t_nack();
        conclude();
    end
    // Tests need about 100k cycles; cut a hang short
    initial begin
        repeat (130000) @(posedge core_clk_i);
        error_cnt++;
        conclude();
    end
endmodule
`default_nettype wire
